// ### frsp_pkg.sv
// Purpose: Shared constants and types for the flash row self-programming controller
// Assumes: 20 MHz system clock, 24-bit program addresses, two addresses per instruction word
// Notes:   Register indices are plain-port indices, not byte addresses
package frsp_pkg;
  // ****************************************
  // Register map (plain port index)
  // ****************************************
  localparam logic [2:0]  REG_CTRL       = 3'h0;  // Control and status
  localparam logic [2:0]  REG_ADDR_LO    = 3'h1;  // Target address bits 15..0
  localparam logic [2:0]  REG_ADDR_HI    = 3'h2;  // Target address bits 23..16
  localparam logic [2:0]  REG_KEY        = 3'h3;  // Unlock key, write only
  localparam logic [2:0]  REG_TABLE_PAGE_REGISTER     = 3'h4;  // Table page register
  // ****************************************
  // Control register fields
  // ****************************************
  localparam int          CTRL_START_BIT = 15;    // Start, set-only
  localparam int          CTRL_WRITE_ENABLE_BIT_BIT  = 14;    // Write enable
  localparam int          CTRL_ERR_BIT   = 13;    // Write error flag
  localparam int          CTRL_OP_MSB    = 6;     // Operation field 6..0
  localparam logic [6:0]  OP_ERASE_ROW   = 7'h41; // Multi-word program flash erase
  localparam logic [6:0]  OP_PROG_ROW    = 7'h01; // Multi-word program flash program
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] ADDR_LO_RESET  = 16'h0000;
  localparam logic [7:0]  ADDR_HI_RESET  = 8'h00;
  localparam logic [7:0]  TABLE_PAGE_REGISTER_RESET   = 8'h00;
  // ****************************************
  // Unlock keys
  // ****************************************
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'hAA;
  // ****************************************
  // Array geometry
  // ****************************************
  localparam int          ROW_WORDS      = 32;    // Instruction words per row
  localparam int          PANEL_ROWS     = 128;   // Rows per panel
  localparam int          ROW_SPAN_LOG2  = 6;     // 32 words x 2 addresses
  localparam int          PANEL_LSB      = 13;    // 128 rows x 64 addresses
  // ****************************************
  // Timing
  // ****************************************
  localparam int          OP_TIME_US     = 2000;  // Nominal erase/program time
  localparam int          CLK_FREQ_KHZ   = 20000;
  localparam int          OP_CYCLES_DEF  = OP_TIME_US * CLK_FREQ_KHZ / 1000;
  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_WAIT} frsp_state_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} frsp_key_t;
endpackage

// ### frsp_latch_if.sv
// Purpose: Carrier between the sequencer and its row write latches
// Assumes: One write port and one asynchronous read port
// Notes:   Sequencer is the master side
`timescale 1ns/1ps
interface frsp_latch_if;
  logic        we;       // Latch write strobe
  logic [4:0]  idx;      // Word index in the row
  logic [1:0]  lo_be;    // Byte enables for bits 15..0
  logic        hi_be;    // Enable for bits 23..16
  logic [23:0] wdata;    // Write data, already placed in lanes
  logic [4:0]  rd_idx;   // Read index for streaming
  logic [23:0] rd_data;  // Read data
  modport master (output we, idx, lo_be, hi_be, wdata, rd_idx, input rd_data);
  modport slave  (input we, idx, lo_be, hi_be, wdata, rd_idx, output rd_data);
endinterface

// ### frsp_latch.sv
// Purpose: Row write latches holding one row of instruction words
// Assumes: Writes come only from the table-write pipeline
// Notes:   Contents are not reset; software must load a full row
`timescale 1ns/1ps
module frsp_latch
  import frsp_pkg::*;
(
  input  wire logic   clk_sys,
  frsp_latch_if.slave lat
);
  // ****************************************
  // Storage
  // ****************************************
  logic [23:0] mem [ROW_WORDS];  // One 24-bit word per instruction

  // Byte-lane write; the high lane is written alone by high-part writes
  always_ff @(posedge clk_sys) begin
    if (lat.we) begin
      if (lat.lo_be[0]) begin
        mem[lat.idx][7:0] <= lat.wdata[7:0];
      end
      if (lat.lo_be[1]) begin
        mem[lat.idx][15:8] <= lat.wdata[15:8];
      end
      if (lat.hi_be) begin
        mem[lat.idx][23:16] <= lat.wdata[23:16];
      end
    end
  end

  // Streaming read for the program cycle
  assign lat.rd_data = mem[lat.rd_idx];
endmodule

// ### frsp_top.sv
// Purpose: Run-time self-programming sequencer for the on-chip program flash
// Assumes: Same-clock core drives table and register ports; nrst is power-on reset
// Notes:   Stall is held for the whole erase or program cycle
// Functional notes
// - Erase one 32-word row at a time
// - Panels of 128 rows each
// - 32-word latches, loaded word 0 upward
// - Table write hits latches only, two cycles
// - Low table ops access bits 15..0
// - High table ops access bits 23..16
// - Address is table page plus effective address
// - Low address register captures table address
// - High address register captures page byte
// - Software may write address registers directly
// - Start only after consecutive 55 then AA
// - Key register reads as zero
// - Cycle lasts 2 ms, core stalled
// - Start bit launches, hardware clears it
// - One program cycle per loaded row
// - Control selects operation and holds start
// - High write uses source low byte only
// - Software can set start, never clear
// - Reset during cycle sets write error
// - Write enable clear at power-up, required
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module frsp_top
  import frsp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = OP_CYCLES_DEF  // Cycles per erase/program
)(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        warm_rst,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        tbl_req,
  input  wire logic        tbl_write,
  input  wire logic        tbl_high,
  input  wire logic        tbl_byte,
  input  wire logic [15:0] tbl_ea,
  input  wire logic [15:0] tbl_wdata,
  output logic      [15:0] tbl_rdata,
  output logic             tbl_done,
  output logic             cpu_stall,
  output logic      [23:0] array_addr,
  output logic      [10:0] array_panel,
  output logic             array_rd,
  input  wire logic [23:0] array_rd_data,
  output logic             array_erase,
  output logic             array_we,
  output logic      [23:0] array_wdata
);
  // ****************************************
  // Helpers
  // ****************************************
  localparam logic [19:0] OP_LAST = 20'(OP_CYCLES - 1);  // Last timer count

  // Word index of an address inside its row
  function automatic logic [4:0] word_idx(input logic [15:0] ea);
    return ea[5:1];
  endfunction

  // First address of the row that holds an address
  function automatic logic [23:0] row_base(input logic [23:0] a);
    return {a[23:ROW_SPAN_LOG2], {ROW_SPAN_LOG2{1'b0}}};
  endfunction

  // ****************************************
  // State
  // ****************************************
  frsp_state_t  state;      // Sequencer state
  frsp_key_t    key_st;     // Unlock progress
  logic         start;      // Start bit, also busy
  logic         write_enable_bit;       // Write enable bit
  logic         err;        // Write error flag
  logic [6:0]   op;         // Selected operation
  logic [15:0]  addr_lo;    // Target address low
  logic [7:0]   addr_hi;    // Target address high
  logic [7:0]   table_page_register;     // Table page register
  logic [19:0]  timer;      // Cycle timer
  logic [4:0]   strm;       // Streaming word counter
  logic         p1_vld;     // Table op in second cycle
  logic         p1_write;
  logic         p1_high;
  logic         p1_byte;
  logic         p1_ea0;
  logic [4:0]   p1_idx;
  logic [15:0]  p1_data;
  frsp_latch_if lat ();     // Latch carrier

  // ****************************************
  // Decode
  // ****************************************
  wire wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
  wire wr_key    = reg_wr && (reg_addr == REG_KEY);
  wire key_ok1   = wr_key && (reg_wdata[7:0] == KEY_FIRST);
  wire key_ok2   = wr_key && (reg_wdata[7:0] == KEY_SECOND) && (key_st == KEY_HALF);
  wire [6:0] new_op = reg_wdata[CTRL_OP_MSB:0];
  wire op_known  = (new_op == OP_ERASE_ROW) || (new_op == OP_PROG_ROW);
  // Start is honoured only straight after the armed key pair
  wire go        = wr_ctrl && reg_wdata[CTRL_START_BIT] && !start && !warm_rst
                   && (key_st == KEY_ARMED) && reg_wdata[CTRL_WRITE_ENABLE_BIT_BIT]
                   && op_known;
  wire op_done   = start && (state == ST_WAIT) && (timer == OP_LAST);
  wire tbl_take  = tbl_req && !start && !warm_rst;
  wire [23:0] tgt = {addr_hi, addr_lo};
  wire [23:0] tbl_full = {table_page_register, tbl_ea};
  wire err_clr   = wr_ctrl && !start && !reg_wdata[CTRL_ERR_BIT];
  wire err_set   = warm_rst && start;

  // ****************************************
  // Unlock sequence
  // ****************************************
  // Any register write other than the keys drops the sequence
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      key_st <= KEY_IDLE;
    end else if (warm_rst) begin
      key_st <= KEY_IDLE;
    end else if (reg_wr) begin
      key_st <= key_ok2 ? KEY_ARMED : (key_ok1 ? KEY_HALF : KEY_IDLE);
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Fields freeze while busy so a running cycle cannot be retargeted
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start <= CTRL_RESET[CTRL_START_BIT];
      write_enable_bit  <= CTRL_RESET[CTRL_WRITE_ENABLE_BIT_BIT];
      op    <= CTRL_RESET[CTRL_OP_MSB:0];
    end else begin
      if (warm_rst || op_done) begin
        start <= 1'b0;
      end else if (go) begin
        start <= 1'b1;
      end
      if (wr_ctrl && !start && !warm_rst) begin
        write_enable_bit <= reg_wdata[CTRL_WRITE_ENABLE_BIT_BIT];
        op   <= new_op;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err <= CTRL_RESET[CTRL_ERR_BIT];
    end else begin
      err <= err_set || (err && !err_clr);
    end
  end

  // ****************************************
  // Address and page registers
  // ****************************************
  // Warm reset leaves these untouched so software can retry the row
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_lo <= ADDR_LO_RESET;
      addr_hi <= ADDR_HI_RESET;
      table_page_register  <= TABLE_PAGE_REGISTER_RESET;
    end else if (!start) begin
      if (tbl_take) begin
        addr_lo <= tbl_ea;
        addr_hi <= table_page_register;
      end else if (reg_wr && (reg_addr == REG_ADDR_LO)) begin
        addr_lo <= reg_wdata;
      end else if (reg_wr && (reg_addr == REG_ADDR_HI)) begin
        addr_hi <= reg_wdata[7:0];
      end
      if (reg_wr && (reg_addr == REG_TABLE_PAGE_REGISTER)) begin
        table_page_register <= reg_wdata[7:0];
      end
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  wire [15:0] ctrl_view = {start, write_enable_bit, err, 6'h00, op};  // Bits 12..7 read zero
  wire [15:0] rd_mux = (reg_addr == REG_CTRL)    ? ctrl_view :
                       (reg_addr == REG_ADDR_LO) ? addr_lo :
                       (reg_addr == REG_ADDR_HI) ? {8'h00, addr_hi} :
                       (reg_addr == REG_TABLE_PAGE_REGISTER)  ? {8'h00, table_page_register} :
                       16'h0000;  // Key and unmapped read zero

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // ****************************************
  // Table pipeline
  // ****************************************
  // Stage one latches the request; the latch write or read return is stage two
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      p1_vld   <= 1'b0;
      p1_write <= 1'b0;
      p1_high  <= 1'b0;
      p1_byte  <= 1'b0;
      p1_ea0   <= 1'b0;
      p1_idx   <= 5'h00;
      p1_data  <= 16'h0000;
      tbl_done <= 1'b0;
    end else begin
      p1_vld   <= tbl_take;
      p1_write <= tbl_write;
      p1_high  <= tbl_high;
      p1_byte  <= tbl_byte;
      p1_ea0   <= tbl_ea[0];
      p1_idx   <= word_idx(tbl_ea);
      p1_data  <= tbl_wdata;
      tbl_done <= p1_vld;
    end
  end

  // Lane placement into the latches; never touches the array
  wire        lo_byte_hi = p1_byte && p1_ea0;
  wire [15:0] lo_data = lo_byte_hi ? {p1_data[7:0], 8'h00} : p1_data;
  assign lat.we    = p1_vld && p1_write;
  assign lat.idx   = p1_idx;
  assign lat.lo_be = (!p1_high && !p1_byte) ? 2'h3 :
                     (!p1_high && p1_byte) ? (p1_ea0 ? 2'h2 : 2'h1) :
                     2'h0;
  // Odd high byte is a phantom lane and is dropped
  assign lat.hi_be = p1_high && !(p1_byte && p1_ea0);
  assign lat.wdata = {p1_data[7:0], lo_data};
  assign lat.rd_idx = strm;

  // Read formatting from the array word
  wire [15:0] rd_lo = !p1_byte ? array_rd_data[15:0] :
                      (p1_ea0 ? {8'h00, array_rd_data[15:8]} : {8'h00, array_rd_data[7:0]});
  wire [15:0] rd_hi = (p1_byte && p1_ea0) ? 16'h0000 : {8'h00, array_rd_data[23:16]};

  // Read result captured at the end of stage two
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tbl_rdata <= 16'h0000;
    end else if (p1_vld && !p1_write) begin
      tbl_rdata <= p1_high ? rd_hi : rd_lo;
    end
  end

  frsp_latch u_latch (
    .clk_sys (clk_sys),
    .lat     (lat.slave)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Timer runs from start; streaming shares the first 32 cycles of it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      timer <= 20'h00000;
      strm  <= 5'h00;
    end else if (warm_rst) begin
      state <= ST_IDLE;
      timer <= 20'h00000;
      strm  <= 5'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          timer <= 20'h00000;
          strm  <= 5'h00;
          if (go) begin
            state <= (new_op == OP_PROG_ROW) ? ST_STREAM : ST_WAIT;
          end
        end
        ST_STREAM: begin
          timer <= timer + 20'h00001;
          strm  <= strm + 5'h01;
          if (strm == 5'(ROW_WORDS - 1)) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          timer <= timer + 20'h00001;
          if (op_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Array drive
  // ****************************************
  // Row-aligned target; the panel index is what page changes must track
  wire [23:0] row_a = row_base(tgt);
  wire [23:0] strm_a = row_a | {18'h00000, strm, 1'b0};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      array_addr  <= 24'h000000;
      array_panel <= 11'h000;
      array_rd    <= 1'b0;
      array_erase <= 1'b0;
      array_we    <= 1'b0;
      array_wdata <= 24'h000000;
    end else begin
      array_rd    <= tbl_take && !tbl_write;
      array_erase <= go && (new_op == OP_ERASE_ROW);
      array_we    <= (state == ST_STREAM);
      array_wdata <= lat.rd_data;
      array_panel <= row_a[23:PANEL_LSB];
      if (tbl_take) begin
        array_addr <= tbl_full;
      end else if (go) begin
        array_addr <= row_a;
      end else if (state == ST_STREAM) begin
        array_addr <= strm_a;
      end
    end
  end

  // Core waits for the whole cycle
  assign cpu_stall = start;

  // ****************************************
  // Checks
  // ****************************************
  start_key_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(start) |-> $past(key_st) == KEY_ARMED && $past(wr_ctrl))
    else $error("start without unlock");
  start_write_enable_bit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(start) |-> write_enable_bit)
    else $error("start without write enable");
  bad_key_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_ctrl && key_st != KEY_ARMED && !start) |=> !start)
    else $error("start after broken key");
  no_sw_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (start && !op_done && !warm_rst) |=> start)
    else $error("start cleared early");
  op_length_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($fell(start) && !$past(warm_rst)) |-> $past(timer) == OP_LAST)
    else $error("cycle length wrong");
  warm_err_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (warm_rst && start) |=> err && !start && $stable(addr_lo))
    else $error("interrupted cycle not flagged");
  tbl_two_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tbl_take |=> (tbl_done == $past(tbl_take, 2)) ##1 tbl_done)
    else $error("table op not two cycles");
  addr_cap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tbl_take |=> addr_lo == $past(tbl_ea) && addr_hi == $past(table_page_register))
    else $error("address not captured");
  busy_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (start && $past(start)) |-> $stable(addr_lo) && $stable(addr_hi) && !lat.we)
    else $error("target moved while busy");
  key_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (reg_rd && reg_addr == REG_KEY) |=> reg_rdata == 16'h0000)
    else $error("key readable");
  stream_cnt_a: assert property (@(posedge clk_sys) disable iff (!nrst || warm_rst)
    $rose(state == ST_STREAM) |=> array_we[*8])
    else $error("row stream broken");
endmodule

// ### frsp_array_model.sv
// Purpose: Behavioural flash array behind the self-programming block
// Assumes: Row of 32 words, two addresses per word, rows on 64-address bounds
// Notes:   Unwritten words read a pattern built from their address
`timescale 1ns/1ps
module frsp_array_model (
  input  wire logic        clk_sys,
  input  wire logic [23:0] array_addr,
  input  wire logic        array_rd,
  input  wire logic        array_erase,
  input  wire logic        array_we,
  input  wire logic [23:0] array_wdata,
  output logic      [23:0] array_rd_data
);
  logic [23:0] mem [logic [23:0]];  // Sparse array contents
  logic        pat = 1'b0;          // Toggles so an idle bus never looks stable
  logic [23:0] rd_word;             // Word at the current address
  // ****************************************
  // Store and erase
  // ****************************************
  always @(posedge clk_sys) begin
    pat <= ~pat;
    // Program one word per streaming cycle
    if (array_we) begin
      mem[array_addr] = array_wdata;
    end
    // Whole row blanked, whatever word the address points into
    if (array_erase) begin
      for (int k = 0; k < 32; k++) begin
        mem[{array_addr[23:6], 6'h00} + 24'(2 * k)] = 24'hFFFFFF;
      end
    end
  end
  // Lookup; page byte folded in so a wrong page reads differently
  always @(array_addr or array_rd) begin
    if (mem.exists(array_addr)) begin
      rd_word = mem[array_addr];
    end else begin
      rd_word = {array_addr[23:16] ^ 8'h3C, array_addr[15:0]};
    end
  end
  // Data only while read is strobed, otherwise a moving pattern
  assign array_rd_data = array_rd ? rd_word : {24{pat}};
endmodule

// ### tb_flash_row_self_program.sv
// Purpose: Self-checking bench for the row self-programming controller
// Assumes: Busy time shortened to 50 cycles through OP_CYCLES
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module tb_flash_row_self_program
  import frsp_pkg::*;
;
  localparam int OPC = 50;  // Short busy time keeps the run brief
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0, warm_rst = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, tbl_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic        tbl_req = 1'b0, tbl_write = 1'b0, tbl_high = 1'b0, tbl_byte = 1'b0;
  logic [15:0] tbl_ea = 16'h0000, tbl_wdata = 16'h0000;
  logic        tbl_done, cpu_stall, array_rd, array_erase, array_we;
  logic [23:0] array_addr, array_rd_data, array_wdata;
  logic [10:0] array_panel;
  int          miscompares = 0, total_checks = 0;
  int          we_cnt = 0, er_cnt = 0, done_cnt = 0, n, d0;
  // ****************************************
  // Clock, design, far side
  // ****************************************
  always #25 clk_sys = ~clk_sys;
  frsp_top #(.OP_CYCLES(OPC)) frsp_top_inst (
    .clk_sys(clk_sys), .nrst(nrst), .warm_rst(warm_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte),
    .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_done(tbl_done),
    .cpu_stall(cpu_stall), .array_addr(array_addr), .array_panel(array_panel),
    .array_rd(array_rd), .array_rd_data(array_rd_data), .array_erase(array_erase),
    .array_we(array_we), .array_wdata(array_wdata));
  frsp_array_model frsp_array_model_inst (
    .clk_sys(clk_sys), .array_addr(array_addr), .array_rd(array_rd),
    .array_erase(array_erase), .array_we(array_we), .array_wdata(array_wdata),
    .array_rd_data(array_rd_data));
  // Event counters for strobes that last one cycle
  always @(posedge clk_sys) begin
    if (array_we === 1'b1) we_cnt++;
    if (array_erase === 1'b1) er_cnt++;
    if (tbl_done === 1'b1) done_cnt++;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // Table op; done must come exactly one edge after the taking edge
  task automatic tbl(input logic w, input logic h, input logic [15:0] ea,
                     input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk_sys);
    tbl_req   <= 1'b1;
    tbl_write <= w;
    tbl_high  <= h;
    tbl_ea    <= ea;
    tbl_wdata <= d;
    @(posedge clk_sys);
    tbl_req   <= 1'b0;
    @(posedge clk_sys);
    #1 chk({23'h0, tbl_done}, 24'h1);
    if (!w) chk({8'h00, tbl_rdata}, {8'h00, exp});
  endtask
  task automatic unlock(input logic [15:0] ctrl);
    wr(REG_KEY, 16'h0055);
    wr(REG_KEY, 16'h00AA);
    wr(REG_CTRL, ctrl);
  endtask
  // Counts stall cycles; mode 0 tries to abort, mode 1 warm resets
  task automatic busy(input int mode, output int cnt);
    cnt = 0;
    #1;
    while (cpu_stall === 1'b1 && cnt < 200) begin
      @(posedge clk_sys);
      reg_addr  <= REG_CTRL;
      reg_wdata <= 16'h4001;
      reg_wr    <= (mode == 0 && cnt == 5);  // Nothing asked right after start
      tbl_write <= 1'b1;
      tbl_req   <= (mode == 0 && cnt == 8);
      warm_rst  <= (mode == 1 && cnt == 10);
      #1 cnt++;
    end
    // A stall that never ends is a failure, not a silent exit
    if (cnt >= 200) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) rdc(3'(a), 16'h0000);
    wr(REG_TABLE_PAGE_REGISTER, 16'h0001);
    // Fill the row; upper byte of the high source is junk on purpose
    for (int k = 0; k < 32; k++) begin
      tbl(1'b1, 1'b0, 16'h6000 + 16'(2 * k), 16'h1000 + 16'(k), 16'h0);
      tbl(1'b1, 1'b1, 16'h6000 + 16'(2 * k), 16'hAB40 + 16'(k), 16'h0);
    end
    rdc(REG_ADDR_LO, 16'h603E);
    rdc(REG_ADDR_HI, 16'h0001);
    // Broken pair straight before the start attempt
    wr(REG_KEY, 16'h0055);
    wr(REG_KEY, 16'h0011);
    wr(REG_CTRL, 16'hC001);
    #1 chk({23'h0, cpu_stall}, 24'h0);
    unlock(16'h8001);
    #1 chk({23'h0, cpu_stall}, 24'h0);
    wr(REG_CTRL, 16'h4001);
    unlock(16'hC001);
    d0 = done_cnt;
    busy(0, n);
    chk(24'(n), 24'(OPC));
    chk(24'(we_cnt), 24'd32);
    chk({13'h0, array_panel}, 24'h016000 >> PANEL_LSB);
    chk(24'(done_cnt), 24'(d0));
    rdc(REG_CTRL, 16'h4001);
    for (int k = 0; k < 32; k += 31) begin
      tbl(1'b0, 1'b0, 16'h6000 + 16'(2 * k), 16'h0, 16'h1000 + 16'(k));
      tbl(1'b0, 1'b1, 16'h6000 + 16'(2 * k), 16'h0, 16'h0040 + 16'(k));
    end
    tbl(1'b0, 1'b1, 16'h0124, 16'h0, 16'h003D);
    // Erase aimed at a word inside the row, set by direct writes
    wr(REG_CTRL, 16'h4041);
    wr(REG_ADDR_HI, 16'h0001);
    wr(REG_ADDR_LO, 16'h6010);
    unlock(16'hC041);
    busy(2, n);
    chk(24'(n), 24'(OPC));
    chk(24'(er_cnt), 24'd1);
    tbl(1'b0, 1'b0, 16'h603E, 16'h0, 16'hFFFF);
    // Warm reset in mid-cycle
    wr(REG_CTRL, 16'h4001);
    wr(REG_ADDR_LO, 16'h6000);
    unlock(16'hC001);
    busy(1, n);
    chk({23'h0, n < OPC}, 24'h1);
    rdc(REG_CTRL, 16'h6001);
    rdc(REG_ADDR_LO, 16'h6000);
    wr(REG_CTRL, 16'h4001);
    rdc(REG_CTRL, 16'h4001);
    final_report();
  end
endmodule
